/* verilog/stc_pkg.sv */
// Constants, register map and field layout of the sixteen bit timer counter.
// Assumes a byte wide register port and a single 100 MHz system clock.
package stc_pkg;
   localparam int unsigned  ADDR_W         = 8;
   localparam int unsigned  DATA_W         = 8;
   localparam int unsigned  COUNT_W        = 16;
   localparam int unsigned  PS_W           = 3;

   // Register offsets
   localparam logic [7:0]   OFS_FLAG       = 8'h0C;
   localparam logic [7:0]   OFS_COUNT_LOW  = 8'h0E;
   localparam logic [7:0]   OFS_COUNT_HIGH = 8'h0F;
   localparam logic [7:0]   OFS_CONTROL    = 8'h10;
   localparam logic [7:0]   OFS_ENABLE     = 8'h8C;

   // Control field positions
   localparam int unsigned  BIT_RUN        = 0;
   localparam int unsigned  BIT_SRC        = 1;
   localparam int unsigned  BIT_SYNC_DIS   = 2;
   localparam int unsigned  BIT_OSC_EN     = 3;
   localparam int unsigned  BIT_PS_LO      = 4;
   localparam int unsigned  BIT_PS_HI      = 5;
   localparam int unsigned  BIT_OSC_STAT   = 6;
   localparam int unsigned  BIT_FLAG       = 0;
   localparam int unsigned  CTRL_W         = 6;

   // Reset and boundary values
   localparam logic [5:0]   CTRL_RESET     = 6'h00;
   localparam logic [15:0]  COUNT_MAX      = 16'hFFFF;
   localparam logic [15:0]  COUNT_ZERO     = 16'h0000;
   localparam logic [7:0]   BYTE_ZERO      = 8'h00;

   // Prescaler terminal counts for 1:1, 1:2, 1:4 and 1:8
   localparam logic [1:0]   PS_DIV1        = 2'h0;
   localparam logic [1:0]   PS_DIV2        = 2'h1;
   localparam logic [1:0]   PS_DIV4        = 2'h2;
   localparam logic [2:0]   PS_MASK1       = 3'h0;
   localparam logic [2:0]   PS_MASK2       = 3'h1;
   localparam logic [2:0]   PS_MASK4       = 3'h3;
   localparam logic [2:0]   PS_MASK8       = 3'h7;

   // Instruction cycle is four system clocks
   localparam int unsigned  CLK_PERIOD_NS  = 10;
   localparam int unsigned  INSTR_NS       = 40;
   localparam int unsigned  INSTR_CYCLES   = (INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0]   PHASE_LAST     = 2'(INSTR_CYCLES - 1);
endpackage : stc_pkg

/* verilog/stc_prescale.sv */
// Input prescaler of the timer counter: divides a tick stream by 1, 2, 4 or 8.
// Assumes tick_in is a one cycle pulse on clk_sys; tick_out follows one cycle later.
`timescale 1ns/1ps
`default_nettype none
module stc_prescale
(
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   input  wire logic                    clr,
   input  wire logic                    tick_in,
   input  wire logic [1:0]              ratio,
   output var  logic                    tick_out
);
   import stc_pkg::*;

   typedef struct packed {
      logic [PS_W-1:0] cnt;
      logic            tick;
   } stc_ps_state_t;

   stc_ps_state_t st_q;
   stc_ps_state_t st_d;
   logic [PS_W-1:0] mask;

   // Terminal count per ratio and next state
   always_comb
   begin
      st_d = st_q;
      st_d.tick = 1'b0;
      case (ratio)
         PS_DIV1: mask = PS_MASK1;
         PS_DIV2: mask = PS_MASK2;
         PS_DIV4: mask = PS_MASK4;
         default: mask = PS_MASK8;
      endcase
      if (clr)
      begin
         st_d.cnt = '0;
      end
      else if (tick_in)
      begin
         if (st_q.cnt >= mask)
         begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
         end
         else
         begin
            st_d.cnt = st_q.cnt + PS_W'(1);
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign tick_out = st_q.tick;
endmodule : stc_prescale
`default_nettype wire

/* verilog/stc_timer.sv */
// Sixteen bit timer counter with prescaler, overflow flag and pin control.
// Assumes a byte register port on clk_sys and asynchronous pins synchronised here.
// What this block does
// - Sixteen bit count in two bytes counts up and wraps from all ones to zero.
// - Wrap sets overflow flag bit 0; interrupt only when enable bit is set.
// - Control bit 0 runs the counter; clear holds the count.
// - Control bit 1 picks instruction cycle ticks or external rising edges.
// - Control bits 5:4 pick prescale divide by 1, 2, 4 or 8.
// - Control bit 6 reads whether system clock comes from this oscillator.
// - Control bit 2 disables synchronising, only meaningful with external source.
// - Oscillator enable forces both pins to inputs reading zero.
// - External edges come from oscillator pin when enabled, else clock pin.
// - After enabling counter mode, a falling edge must precede any count.
// - Prescaler counts external edges; its output is synchronised to the core.
// - Synchronised counter mode holds the count in sleep; prescaler keeps going.
// - Unsynchronised counter mode counts in sleep and its overflow can interrupt.
// - Unsynchronised counting is not offered as capture or compare time base.
// - Count byte reads return a stable value in unsynchronised mode.
// - Special event trigger input clears the count.
// - Oscillator runs in every power managed mode once enabled.
// - Control bit 7 reads zero; control bits 5:0 reset to zero.
// - A count write beats a coinciding special event trigger.
// - The special event trigger clear does not set the overflow flag.
// - Any count byte write clears the prescaler.
// - Reset clears control, flag and enable; the count bytes keep their value.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module stc_timer
(
   input  wire logic                         clk_sys,
   input  wire logic                         rst_n,
   input  wire logic [stc_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [stc_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_we,
   input  wire logic                         reg_re,
   output var  logic [stc_pkg::DATA_W-1:0]   reg_rdata,
   input  wire logic                         osc_input_pin,
   input  wire logic                         external_clock_pin,
   input  wire logic [1:0]                   port_direction_bits,
   input  wire logic                         sleep_mode,
   input  wire logic                         sysclk_from_osc,
   input  wire logic                         special_event_reset,
   output var  logic [1:0]                   pin_oe,
   output var  logic [1:0]                   port_read,
   output var  logic                         osc_amp_enable,
   output var  logic                         overflow_irq,
   output var  logic                         timebase_valid,
   output var  logic [stc_pkg::COUNT_W-1:0]  count_pair
);
   import stc_pkg::*;

   typedef struct packed {
      logic [CTRL_W-1:0]  ctrl;
      logic [COUNT_W-1:0] count;
      logic               flag;
      logic               irq_en;
      logic [1:0]         sync1;
      logic [1:0]         sync2;
      logic               edge_prev;
      logic               armed;
      logic [1:0]         phase;
      logic [DATA_W-1:0]  rdata;
      logic               irq;
      logic               tb_valid;
      logic [1:0]         pin_oe;
      logic [1:0]         port_rd;
      logic               osc_amp;
      logic               seeded;
   } stc_state_t;

   stc_state_t st_q;
   stc_state_t st_d;

   logic run_on;
   logic src_ext;
   logic async_mode;
   logic osc_en;
   logic ext_level;
   logic ext_rise;
   logic ext_fall;
   logic ps_in;
   logic ps_tick;
   logic wr_low;
   logic wr_high;
   logic cnt_wr;
   logic cnt_inc;
   logic wrap;
   logic [DATA_W-1:0] ctrl_rd;

   // Control field views and pin edge detection
   assign run_on     = st_q.ctrl[BIT_RUN];
   assign src_ext    = st_q.ctrl[BIT_SRC];
   assign async_mode = src_ext & st_q.ctrl[BIT_SYNC_DIS];
   assign osc_en     = st_q.ctrl[BIT_OSC_EN];
   assign ext_level  = osc_en ? st_q.sync2[1] : st_q.sync2[0];
   assign ext_rise   = ext_level & ~st_q.edge_prev;
   assign ext_fall   = ~ext_level & st_q.edge_prev;
   assign wr_low     = reg_we && (reg_addr == OFS_COUNT_LOW);
   assign wr_high    = reg_we && (reg_addr == OFS_COUNT_HIGH);
   assign cnt_wr     = wr_low | wr_high;

   // Prescaler input: armed external edges or instruction cycle ticks
   always_comb
   begin
      ps_in = 1'b0;
      if (run_on && src_ext)
         ps_in = ext_rise & st_q.armed;
      else if (run_on)
         ps_in = (st_q.phase == PHASE_LAST) & ~sleep_mode;
   end

   // Divider, cleared by any count write
   stc_prescale u_prescale
   (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .clr      (cnt_wr),
      .tick_in  (ps_in),
      .ratio    (st_q.ctrl[BIT_PS_HI:BIT_PS_LO]),
      .tick_out (ps_tick)
   );

   // Synchronised mode stalls in sleep, unsynchronised keeps counting
   assign cnt_inc = ps_tick & run_on & ~(sleep_mode & ~async_mode);
   assign wrap    = cnt_inc && (st_q.count == COUNT_MAX) && !cnt_wr && !special_event_reset;
   assign ctrl_rd = {1'b0, sysclk_from_osc, st_q.ctrl};

   // Next state of the whole block
   always_comb
   begin
      st_d = st_q;
      // Two stage synchronisers for both pins
      st_d.sync1 = {osc_input_pin, external_clock_pin};
      st_d.sync2 = st_q.sync1;
      st_d.edge_prev = ext_level;
      st_d.phase = st_q.phase + 2'(1);
      // Arming waits for a falling edge after entering counter mode
      if (!(run_on && src_ext))
         st_d.armed = 1'b0;
      else if (ext_fall)
         st_d.armed = 1'b1;
      // Count: write first, then trigger clear, then increment
      if (cnt_wr)
      begin
         if (wr_low)
            st_d.count[7:0] = reg_wdata;
         if (wr_high)
            st_d.count[15:8] = reg_wdata;
      end
      else if (special_event_reset)
         st_d.count = COUNT_ZERO;
      else if (cnt_inc)
         st_d.count = st_q.count + COUNT_W'(1);
      // Register writes
      if (reg_we && (reg_addr == OFS_CONTROL))
         st_d.ctrl = reg_wdata[CTRL_W-1:0];
      if (reg_we && (reg_addr == OFS_ENABLE))
         st_d.irq_en = reg_wdata[BIT_FLAG];
      if (reg_we && (reg_addr == OFS_FLAG))
         st_d.flag = reg_wdata[BIT_FLAG];
      // Overflow wins over a clear in the same cycle
      if (wrap)
         st_d.flag = 1'b1;
      // Read data, valid the cycle after the strobe only
      st_d.rdata = BYTE_ZERO;
      if (reg_re)
      begin
         if (reg_addr == OFS_COUNT_LOW)
            st_d.rdata = st_q.count[7:0];
         else if (reg_addr == OFS_COUNT_HIGH)
            st_d.rdata = st_q.count[15:8];
         else if (reg_addr == OFS_CONTROL)
            st_d.rdata = ctrl_rd;
         else if (reg_addr == OFS_FLAG)
            st_d.rdata = {7'h00, st_q.flag};
         else if (reg_addr == OFS_ENABLE)
            st_d.rdata = {7'h00, st_q.irq_en};
      end
      // Registered side outputs
      st_d.irq      = st_q.flag & st_q.irq_en;
      st_d.tb_valid = ~async_mode;
      st_d.pin_oe   = osc_en ? 2'h0 : ~port_direction_bits;
      st_d.port_rd  = osc_en ? 2'h0 : st_q.sync2;
      st_d.osc_amp  = osc_en;
      // Count is unknown until software or the trigger loads it
      if (cnt_wr || special_event_reset)
         st_d.seeded = 1'b1;
   end

   // State register; the count is left out of reset
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q.ctrl      <= CTRL_RESET;
         st_q.flag      <= 1'b0;
         st_q.irq_en    <= 1'b0;
         st_q.sync1     <= 2'h0;
         st_q.sync2     <= 2'h0;
         st_q.edge_prev <= 1'b0;
         st_q.armed     <= 1'b0;
         st_q.phase     <= 2'h0;
         st_q.rdata     <= BYTE_ZERO;
         st_q.irq       <= 1'b0;
         st_q.tb_valid  <= 1'b1;
         st_q.pin_oe    <= 2'h0;
         st_q.port_rd   <= 2'h0;
         st_q.osc_amp   <= 1'b0;
         st_q.seeded    <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata      = st_q.rdata;
   assign pin_oe         = st_q.pin_oe;
   assign port_read      = st_q.port_rd;
   assign osc_amp_enable = st_q.osc_amp;
   assign overflow_irq   = st_q.irq;
   assign timebase_valid = st_q.tb_valid;
   assign count_pair     = st_q.count;

   // Checks on the block's own behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence ctrl_read;
      reg_re && (reg_addr == OFS_CONTROL);
   endsequence

   sequence quiet_count;
      !cnt_wr && !special_event_reset;
   endsequence

   chk_wrap_to_zero: assert property (wrap |=> count_pair == COUNT_ZERO)
      else $error("count did not wrap to zero");

   chk_wrap_sets_flag: assert property (wrap |=> st_q.flag)
      else $error("wrap did not set overflow flag");

   chk_flag_sticky: assert property (st_q.flag && !(reg_we && reg_addr == OFS_FLAG)
      |=> st_q.flag)
      else $error("overflow flag dropped without a clear");

   chk_stop_holds: assert property ((st_q.seeded && !run_on && !ps_tick) ##0 quiet_count
      |=> $stable(count_pair))
      else $error("stopped counter changed");

   chk_osc_pins_in: assert property (osc_en |=> (pin_oe == 2'h0) && (port_read == 2'h0))
      else $error("oscillator pins not forced to input");

   chk_unarmed_quiet: assert property (run_on && src_ext && !st_q.armed |-> !ps_in)
      else $error("edge counted before falling edge");

   chk_sleep_sync: assert property (sleep_mode && src_ext && !async_mode ##0 quiet_count
      |=> $stable(count_pair))
      else $error("synchronised count moved in sleep");

   chk_async_base: assert property (async_mode |=> !timebase_valid)
      else $error("unsynchronised count offered as time base");

   chk_trigger_clear: assert property (special_event_reset && !cnt_wr
      |=> count_pair == COUNT_ZERO)
      else $error("trigger did not clear count");

   chk_write_first: assert property (wr_low && special_event_reset
      |=> count_pair[7:0] == $past(reg_wdata))
      else $error("trigger beat a count write");

   chk_trigger_noflag: assert property (special_event_reset && !st_q.flag
      && !(reg_we && reg_addr == OFS_FLAG) |=> !st_q.flag)
      else $error("trigger set overflow flag");

   chk_ctrl_bit7: assert property (ctrl_read |=> reg_rdata[7] == 1'b0 ##0
      reg_rdata[BIT_OSC_STAT] == $past(sysclk_from_osc))
      else $error("control read shows wrong top bits");

   chk_irq_gate: assert property (!st_q.irq_en |=> !overflow_irq)
      else $error("interrupt raised while disabled");
endmodule : stc_timer
`default_nettype wire

/* sim/stc_clk_source.sv */
// Behavioural far side: external clock source and watch crystal on the two count pins.
// Assumes pulse() is called from the bench's main process; pins idle low between pulses.
`timescale 1ns/1ps
`default_nettype none
module stc_clk_source
(
   input  wire logic clk_sys,
   output var  logic external_clock_pin,
   output var  logic osc_input_pin
);
   localparam int HALF = 5; // Clocks per level, above the two the synchroniser needs

   initial
   begin
      external_clock_pin = 1'b0;
      osc_input_pin      = 1'b0;
   end

   // One rise then one fall per pulse on the chosen pin; the other pin stays still
   task automatic pulse(input logic use_osc, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_sys);
         if (use_osc)
            osc_input_pin <= 1'b1;
         else
            external_clock_pin <= 1'b1;
         repeat (HALF) @(posedge clk_sys);
         osc_input_pin      <= 1'b0;
         external_clock_pin <= 1'b0;
         repeat (HALF) @(posedge clk_sys);
      end
   endtask : pulse
endmodule : stc_clk_source
`default_nettype wire

/* sim/test_sixteen_bit_timer_counter.sv */
// Self-checking bench for the sixteen bit timer counter, driven by register bus calls.
// Assumes the design package, design and pin source model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_sixteen_bit_timer_counter;
   import stc_pkg::*;
   logic        clk_sys;
   logic        rst_n;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_we;
   logic        reg_re;
   logic [7:0]  reg_rdata;
   logic        ext_pin;
   logic        osc_pin;
   logic [1:0]  dir_bits;
   logic        sleep_mode;
   logic        sysclk_from_osc;
   logic        sev_reset;
   logic [1:0]  pin_oe;
   logic [1:0]  port_read;
   logic        osc_amp_enable;
   logic        overflow_irq;
   logic        timebase_valid;
   logic [15:0] count_pair;
   logic [15:0] c0;
   logic [15:0] e;
   int          n_errors;
   int          check_count;

   // Free running 100 MHz clock
   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;

   // Bus write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_we <= 1'b0;
   endtask : wr

   // Wait n edges, then step past the edge updates
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc

   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Bus read; data is sampled in the one cycle it stands
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_sys);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_re <= 1'b0;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, exp}, what);
   endtask : rdc

   task automatic test_done();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   stc_timer stc_timer_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .osc_input_pin(osc_pin),
      .external_clock_pin(ext_pin), .port_direction_bits(dir_bits),
      .sleep_mode(sleep_mode), .sysclk_from_osc(sysclk_from_osc),
      .special_event_reset(sev_reset), .pin_oe(pin_oe), .port_read(port_read),
      .osc_amp_enable(osc_amp_enable), .overflow_irq(overflow_irq),
      .timebase_valid(timebase_valid), .count_pair(count_pair));

   stc_clk_source stc_clk_source_inst (
      .clk_sys(clk_sys), .external_clock_pin(ext_pin), .osc_input_pin(osc_pin));

   // Watchdog cuts a hang short
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      n_errors++;
      test_done();
   end

   // Main sequence
   initial
   begin
      rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; reg_we = 1'b0; reg_re = 1'b0;
      dir_bits = 2'b01; sleep_mode = 1'b0; sysclk_from_osc = 1'b0; sev_reset = 1'b0;
      n_errors = 0; check_count = 0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdc(OFS_CONTROL, 8'h00, "ctrl reset");
      sysclk_from_osc <= 1'b1;
      rdc(OFS_CONTROL, 8'h40, "clk status");
      sysclk_from_osc <= 1'b0;
      wr(OFS_CONTROL, 8'hFF);
      rdc(OFS_CONTROL, 8'h3F, "ctrl ro bits");
      chk({10'h000, pin_oe, port_read, 1'b0, osc_amp_enable}, 16'h0001, "osc pins");
      wr(OFS_CONTROL, 8'h00);
      cyc(2);
      chk({14'h0, pin_oe}, 16'h0002, "pin dir");
      rdc(8'h55, 8'h00, "unmapped");
      $display("test registers done");
      wr(OFS_COUNT_LOW, 8'h34);
      wr(OFS_COUNT_HIGH, 8'h12);
      rdc(OFS_COUNT_HIGH, 8'h12, "high");
      rdc(OFS_COUNT_LOW, 8'h34, "low");
      rdc(OFS_COUNT_HIGH, 8'h12, "high again");
      cyc(50);
      chk(count_pair, 16'h1234, "stopped");
      $display("test count bytes done");
      for (int ps = 0; ps < 4; ps++)
      begin
         wr(OFS_CONTROL, {2'b00, 2'(ps), 1'b0, 1'(ps), 2'b01});
         cyc(4);
         c0 = count_pair;
         cyc(320);
         e = 16'(80 >> ps);
         c0 = count_pair - c0;
         check_count++;
         if ((c0 + 16'h0001 >= e && c0 <= e + 16'h0001) !== 1'b1)
         begin
            n_errors++;
            $display("ERROR %0t timer rate got %h exp %h", $time, c0, e);
         end
         chk({15'h0, timebase_valid}, 16'h0001, "timer base");
      end
      $display("test timer mode done");
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_COUNT_LOW, 8'hFE);
      wr(OFS_COUNT_HIGH, 8'hFF);
      wr(OFS_CONTROL, 8'h01);
      cyc(30);
      wr(OFS_CONTROL, 8'h00);
      chk({15'h0, overflow_irq}, 16'h0000, "irq masked");
      wr(OFS_ENABLE, 8'h01);
      cyc(100);
      chk({15'h0, overflow_irq}, 16'h0001, "irq on");
      rdc(OFS_FLAG, 8'h01, "flag held");
      wr(OFS_FLAG, 8'h00);
      cyc(2);
      chk({15'h0, overflow_irq}, 16'h0000, "irq off");
      $display("test overflow done");
      @(posedge clk_sys);
      sev_reset <= 1'b1;
      @(posedge clk_sys);
      sev_reset <= 1'b0;
      cyc(2);
      chk(count_pair, 16'h0000, "trigger");
      rdc(OFS_FLAG, 8'h00, "trigger flag");
      @(posedge clk_sys);
      reg_we <= 1'b1; reg_addr <= OFS_COUNT_LOW; reg_wdata <= 8'h55; sev_reset <= 1'b1;
      @(posedge clk_sys);
      reg_we <= 1'b0; sev_reset <= 1'b0;
      cyc(2);
      chk({8'h00, count_pair[7:0]}, 16'h0055, "write wins");
      $display("test trigger done");
      for (int m = 0; m < 2; m++)
      begin
         wr(OFS_CONTROL, 8'h00);
         wr(OFS_COUNT_LOW, 8'h00);
         wr(OFS_COUNT_HIGH, 8'h00);
         wr(OFS_CONTROL, (m == 1) ? 8'h0B : 8'h03);
         cyc(20);
         stc_clk_source_inst.pulse(1'(1 - m), 3);
         stc_clk_source_inst.pulse(1'(m), 4);
         cyc(10);
         chk(count_pair, 16'h0003, "ext count");
      end
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_COUNT_LOW, 8'hFE);
      wr(OFS_COUNT_HIGH, 8'hFF);
      wr(OFS_CONTROL, 8'h07);
      sleep_mode <= 1'b1;
      stc_clk_source_inst.pulse(1'b0, 5);
      cyc(10);
      chk(count_pair, 16'h0002, "unsync sleep");
      chk({15'h0, overflow_irq}, 16'h0001, "wake irq");
      chk({15'h0, timebase_valid}, 16'h0000, "unsync base");
      sleep_mode <= 1'b0;
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_FLAG, 8'h00);
      wr(OFS_COUNT_LOW, 8'h00);
      wr(OFS_COUNT_HIGH, 8'h00);
      wr(OFS_CONTROL, 8'h03);
      sleep_mode <= 1'b1;
      stc_clk_source_inst.pulse(1'b0, 5);
      cyc(10);
      chk(count_pair, 16'h0000, "sync sleep");
      chk({15'h0, timebase_valid}, 16'h0001, "sync base");
      sleep_mode <= 1'b0;
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_CONTROL, 8'h33);
      stc_clk_source_inst.pulse(1'b0, 6);
      wr(OFS_COUNT_LOW, 8'h00);
      stc_clk_source_inst.pulse(1'b0, 7);
      cyc(10);
      chk(count_pair, 16'h0000, "ps cleared");
      stc_clk_source_inst.pulse(1'b0, 1);
      cyc(10);
      chk(count_pair, 16'h0001, "ps eighth");
      $display("test counter mode done");
      test_done();
   end
endmodule : test_sixteen_bit_timer_counter
`default_nettype wire
